// File: ccr_pkg.sv
// constants, field layout and types of the charger configuration register bank
package ccr_pkg;

    localparam logic [6:0] CCR_SLAVE_ADDR     = 7'h4B;

    localparam logic [7:0] CCR_OFS_VIN_FLOOR  = 8'h01;
    localparam logic [7:0] CCR_OFS_THERMAL    = 8'h02;
    localparam logic [7:0] CCR_OFS_CONV_BOOST = 8'h03;
    localparam logic [7:0] CCR_OFS_CHG_SYS    = 8'h04;

    // power-on values of the four registers
    localparam logic [7:0] CCR_RST_VIN_FLOOR  = 8'h06;
    localparam logic [7:0] CCR_RST_THERMAL    = 8'hDC;
    localparam logic [7:0] CCR_RST_CONV_BOOST = 8'h10;
    localparam logic [7:0] CCR_RST_CHG_SYS    = 8'h5B;

    // bits restored on watchdog expiry
    localparam logic [7:0] CCR_WDT_VIN_FLOOR  = 8'h00;
    localparam logic [7:0] CCR_WDT_THERMAL    = 8'hFE;
    localparam logic [7:0] CCR_WDT_CONV_BOOST = 8'hFF;
    localparam logic [7:0] CCR_WDT_CHG_SYS    = 8'hF0;

    // bits stored by a bus write
    localparam logic [7:0] CCR_WR_VIN_FLOOR   = 8'h7F;
    localparam logic [7:0] CCR_WR_THERMAL     = 8'hFF;
    localparam logic [7:0] CCR_WR_CONV_BOOST  = 8'h7F;
    localparam logic [7:0] CCR_WR_CHG_SYS     = 8'hFF;

    // bits loaded by hardware on input power-up
    localparam logic [7:0] CCR_HW_VIN_FLOOR   = 8'h7F;

    // field positions
    localparam int CCR_POS_SOFT_RST      = 7;
    localparam int CCR_POS_SHIP_DLY      = 7;
    localparam int CCR_POS_NTC_PROFILE   = 6;
    localparam int CCR_POS_BOOST_NTC     = 5;
    localparam int CCR_POS_CHG_NTC       = 4;
    localparam int CCR_POS_DIE_THR       = 2;
    localparam int CCR_POS_NTC_SRC       = 1;
    localparam int CCR_POS_AICO          = 0;
    localparam int CCR_POS_ADC_GO        = 7;
    localparam int CCR_POS_ADC_REPEAT    = 6;
    localparam int CCR_POS_BOOST_V       = 3;
    localparam int CCR_POS_BOOST_I       = 0;
    localparam int CCR_POS_BAT_LOAD      = 7;
    localparam int CCR_POS_STAT_EN       = 6;
    localparam int CCR_POS_CHG_FUNC      = 4;
    localparam int CCR_POS_SYS_FLOOR     = 1;
    localparam int CCR_POS_TRACK         = 0;

    localparam logic [3:0] CCR_BITS_DATA = 4'h8;
    localparam logic [3:0] CCR_BITS_ACK  = 4'h9;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_REG   = 5'h04,
        ST_WDATA = 5'h08,
        ST_RDATA = 5'h10
    } ccr_state_t;

endpackage

// File: ccr_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
module ccr_pin_sync
    import ccr_pkg::*;
#(
    parameter int         N        = 2,
    parameter logic [1:0] IDLE_VAL = 2'h3
)(
    input  wire logic         i_mclk,
    input  wire logic         i_sys_rst,
    input  wire logic [N-1:0] i_pin,
    output logic      [N-1:0] o_level
);

    if (N < 1 || N > 2)
    begin : g_chk
        $error("ccr_pin_sync: N must be 1 or 2");
    end

    for (genvar k = 0; k < N; k++)
    begin : g_bit
        logic s1_ff;
        logic s2_ff;
        logic s3_ff;
        logic lvl_ff;
        logic nxt_lvl;

        // the level only moves once the second and third stages agree
        always_comb
        begin
            nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
        end

        always_ff @(posedge i_mclk or posedge i_sys_rst)
        begin
            if (i_sys_rst)
            begin
                s1_ff  <= IDLE_VAL[k];
                s2_ff  <= IDLE_VAL[k];
                s3_ff  <= IDLE_VAL[k];
                lvl_ff <= IDLE_VAL[k];
            end
            else
            begin
                s1_ff  <= i_pin[k];
                s2_ff  <= s1_ff;
                s3_ff  <= s2_ff;
                lvl_ff <= nxt_lvl;
            end
        end

        assign o_level[k] = lvl_ff;
    end

endmodule

// File: ccr_cfg_byte.sv
// one configuration byte with power-on, soft, watchdog and hardware-load updates
module ccr_cfg_byte
    import ccr_pkg::*;
#(
    parameter int         WIDTH    = 8,
    parameter logic [7:0] RST_VAL  = 8'h00,
    parameter logic [7:0] WDT_MASK = 8'h00,
    parameter logic [7:0] WR_MASK  = 8'hFF,
    parameter logic [7:0] HW_MASK  = 8'h00
)(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_soft_rst,
    input  wire logic       i_wdt,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_hw_load,
    input  wire logic [7:0] i_hw_data,
    output logic      [7:0] o_value
);

    if (WIDTH != 8)
    begin : g_chk
        $error("ccr_cfg_byte: only byte-wide registers are supported");
    end

    logic [7:0] val_ff;
    logic [7:0] nxt_val;

    // soft reset beats a write, a write beats a hardware load, which beats watchdog restore
    always_comb
    begin
        nxt_val = val_ff;
        if (i_wdt)
        begin
            nxt_val = (val_ff & ~WDT_MASK) | (RST_VAL & WDT_MASK);
        end
        if (i_hw_load)
        begin
            nxt_val = (nxt_val & ~HW_MASK) | (i_hw_data & HW_MASK);
        end
        if (i_wr_en)
        begin
            nxt_val = (nxt_val & ~WR_MASK) | (i_wr_data & WR_MASK);
        end
        if (i_soft_rst)
        begin
            nxt_val = RST_VAL;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            val_ff <= RST_VAL;
        end
        else
        begin
            val_ff <= nxt_val;
        end
    end

    assign o_value = val_ff;

endmodule

// File: ccr_charger_cfg.sv
// charger configuration register bank behind a two-wire serial slave port
module ccr_charger_cfg
    import ccr_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = CCR_SLAVE_ADDR
)(
    input  wire logic       i_mclk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    output logic            o_sda,
    output logic            o_sda_oe_n,
    input  wire logic       i_watchdog_expiry,
    input  wire logic       i_vin_power_up,
    input  wire logic [6:0] i_otp_vin_floor,
    input  wire logic       i_adc_busy,
    input  wire logic       i_adc_done,
    output logic [6:0]      o_vin_floor_code,
    output logic            o_ship_delay_en,
    output logic            o_thermistor_profile,
    output logic            o_boost_thermistor_enable,
    output logic            o_charge_thermistor_enable,
    output logic [1:0]      o_die_temp_thr,
    output logic            o_thermistor_source_sel,
    output logic            o_auto_input_current_opt_enable,
    output logic            o_adc_go,
    output logic            o_adc_continuous,
    output logic [2:0]      o_boost_voltage_set,
    output logic [2:0]      o_boost_current_limit,
    output logic            o_battery_load_enable,
    output logic            o_status_pin_enable,
    output logic [1:0]      o_charge_function_sel,
    output logic [2:0]      o_sys_floor_code,
    output logic            o_battery_track_offset
);

    logic [1:0]  pin_lvl;
    logic        scl_lvl;
    logic        sda_lvl;
    logic        scl_d_ff;
    logic        sda_d_ff;
    logic        scl_rise;
    logic        scl_fall;
    logic        bus_start;
    logic        bus_stop;

    ccr_state_t  state_ff;
    ccr_state_t  nxt_state;
    logic [3:0]  bit_cnt_ff;
    logic [3:0]  nxt_bit_cnt;
    logic [7:0]  shift_ff;
    logic [7:0]  nxt_shift;
    logic [7:0]  ptr_ff;
    logic [7:0]  nxt_ptr;
    logic        rw_ff;
    logic        nxt_rw;
    logic        nack_ff;
    logic        nxt_nack;
    logic        sda_oe_n_ff;
    logic        nxt_sda_oe_n;

    logic        wr_fire;
    logic        soft_rst;
    logic        wr_vin;
    logic        wr_thermal;
    logic        wr_conv;
    logic        wr_chg;
    logic [7:0]  reg_vin;
    logic [7:0]  reg_thermal;
    logic [7:0]  reg_conv;
    logic [7:0]  reg_chg;
    logic [7:0]  rd_byte;

    logic        adc_go_ff;
    logic        nxt_adc_go;

    ccr_pin_sync #(
        .N        (2),
        .IDLE_VAL (2'h3)
    ) u_sync (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_pin     ({i_sda, i_scl}),
        .o_level   (pin_lvl)
    );

    assign scl_lvl = pin_lvl[0];
    assign sda_lvl = pin_lvl[1];

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end
        else
        begin
            scl_d_ff <= scl_lvl;
            sda_d_ff <= sda_lvl;
        end
    end

    assign scl_rise  = scl_lvl & ~scl_d_ff;
    assign scl_fall  = ~scl_lvl & scl_d_ff;
    // sda moving while scl stays high frames a transfer
    assign bus_start = scl_lvl & scl_d_ff & sda_d_ff & ~sda_lvl;
    assign bus_stop  = scl_lvl & scl_d_ff & ~sda_d_ff & sda_lvl;

    // bit 7 of the input-floor byte is never stored, so it reads back as zero
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (ptr_ff)
            CCR_OFS_VIN_FLOOR:  rd_byte = reg_vin;
            CCR_OFS_THERMAL:    rd_byte = reg_thermal;
            CCR_OFS_CONV_BOOST: rd_byte = {adc_go_ff | i_adc_busy, reg_conv[6:0]};
            CCR_OFS_CHG_SYS:    rd_byte = reg_chg;
            default:            rd_byte = 8'h00;
        endcase
    end

    // serial slave: data sampled on scl rise, the slave drives sda only after scl falls
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_bit_cnt  = bit_cnt_ff;
        nxt_shift    = shift_ff;
        nxt_ptr      = ptr_ff;
        nxt_rw       = rw_ff;
        nxt_nack     = nack_ff;
        nxt_sda_oe_n = sda_oe_n_ff;
        if (bus_start)
        begin
            nxt_state    = ST_ADDR;
            nxt_bit_cnt  = 4'h0;
            nxt_sda_oe_n = 1'b1;
        end
        else if (bus_stop)
        begin
            nxt_state    = ST_IDLE;
            nxt_sda_oe_n = 1'b1;
        end
        else if (state_ff != ST_IDLE && scl_rise)
        begin
            if (bit_cnt_ff < CCR_BITS_DATA && state_ff != ST_RDATA)
            begin
                nxt_shift = {shift_ff[6:0], sda_lvl};
            end
            if (bit_cnt_ff == CCR_BITS_DATA && state_ff == ST_RDATA)
            begin
                nxt_nack = sda_lvl;
            end
            if (bit_cnt_ff < CCR_BITS_ACK)
            begin
                nxt_bit_cnt = bit_cnt_ff + 4'h1;
            end
        end
        else if (state_ff != ST_IDLE && scl_fall)
        begin
            if (bit_cnt_ff == CCR_BITS_DATA)
            begin
                unique case (state_ff)
                    ST_ADDR:
                    begin
                        if (shift_ff[7:1] == SLAVE_ADDR)
                        begin
                            nxt_rw       = shift_ff[0];
                            nxt_sda_oe_n = 1'b0;
                        end
                        else
                        begin
                            nxt_state = ST_IDLE;
                        end
                    end
                    ST_REG:
                    begin
                        nxt_ptr      = shift_ff;
                        nxt_sda_oe_n = 1'b0;
                    end
                    ST_WDATA:
                    begin
                        nxt_ptr      = ptr_ff + 8'h01;
                        nxt_sda_oe_n = 1'b0;
                    end
                    ST_RDATA:
                    begin
                        nxt_sda_oe_n = 1'b1;
                    end
                    default:
                    begin
                        nxt_state = ST_IDLE;
                    end
                endcase
            end
            else if (bit_cnt_ff == CCR_BITS_ACK)
            begin
                nxt_bit_cnt  = 4'h0;
                nxt_sda_oe_n = 1'b1;
                unique case (state_ff)
                    ST_ADDR:
                    begin
                        if (rw_ff)
                        begin
                            nxt_state    = ST_RDATA;
                            nxt_shift    = rd_byte;
                            nxt_ptr      = ptr_ff + 8'h01;
                            nxt_sda_oe_n = rd_byte[7];
                        end
                        else
                        begin
                            nxt_state = ST_REG;
                        end
                    end
                    ST_REG:
                    begin
                        nxt_state = ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        nxt_state = ST_WDATA;
                    end
                    ST_RDATA:
                    begin
                        // a master nack ends the read and leaves sda released
                        if (nack_ff)
                        begin
                            nxt_state = ST_IDLE;
                        end
                        else
                        begin
                            nxt_shift    = rd_byte;
                            nxt_ptr      = ptr_ff + 8'h01;
                            nxt_sda_oe_n = rd_byte[7];
                        end
                    end
                    default:
                    begin
                        nxt_state = ST_IDLE;
                    end
                endcase
            end
            else if (state_ff == ST_RDATA)
            begin
                nxt_sda_oe_n = shift_ff[3'(7 - bit_cnt_ff)]; // msb first
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_ff    <= ST_IDLE;
            bit_cnt_ff  <= 4'h0;
            shift_ff    <= 8'h00;
            ptr_ff      <= 8'h00;
            rw_ff       <= 1'b0;
            nack_ff     <= 1'b1;
            sda_oe_n_ff <= 1'b1;
        end
        else
        begin
            state_ff    <= nxt_state;
            bit_cnt_ff  <= nxt_bit_cnt;
            shift_ff    <= nxt_shift;
            ptr_ff      <= nxt_ptr;
            rw_ff       <= nxt_rw;
            nack_ff     <= nxt_nack;
            sda_oe_n_ff <= nxt_sda_oe_n;
        end
    end

    // open drain: the pin is only ever pulled low
    assign o_sda      = 1'b0;
    assign o_sda_oe_n = sda_oe_n_ff;

    // a data byte lands when its ack slot opens, bus start/stop never overlap an scl fall
    assign wr_fire    = (state_ff == ST_WDATA) && scl_fall && (bit_cnt_ff == CCR_BITS_DATA) && !bus_start && !bus_stop;
    assign wr_vin     = wr_fire && (ptr_ff == CCR_OFS_VIN_FLOOR);
    assign wr_thermal = wr_fire && (ptr_ff == CCR_OFS_THERMAL);
    assign wr_conv    = wr_fire && (ptr_ff == CCR_OFS_CONV_BOOST);
    assign wr_chg     = wr_fire && (ptr_ff == CCR_OFS_CHG_SYS);
    assign soft_rst   = wr_vin && shift_ff[CCR_POS_SOFT_RST];

    ccr_cfg_byte #(
        .RST_VAL  (CCR_RST_VIN_FLOOR),
        .WDT_MASK (CCR_WDT_VIN_FLOOR),
        .WR_MASK  (CCR_WR_VIN_FLOOR),
        .HW_MASK  (CCR_HW_VIN_FLOOR)
    ) u_vin (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_soft_rst(soft_rst),
        .i_wdt     (i_watchdog_expiry),
        .i_wr_en   (wr_vin),
        .i_wr_data (shift_ff),
        .i_hw_load (i_vin_power_up),
        .i_hw_data ({1'b0, i_otp_vin_floor}),
        .o_value   (reg_vin)
    );

    ccr_cfg_byte #(
        .RST_VAL  (CCR_RST_THERMAL),
        .WDT_MASK (CCR_WDT_THERMAL),
        .WR_MASK  (CCR_WR_THERMAL),
        .HW_MASK  (8'h00)
    ) u_thermal (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_soft_rst(soft_rst),
        .i_wdt     (i_watchdog_expiry),
        .i_wr_en   (wr_thermal),
        .i_wr_data (shift_ff),
        .i_hw_load (1'b0),
        .i_hw_data (8'h00),
        .o_value   (reg_thermal)
    );

    ccr_cfg_byte #(
        .RST_VAL  (CCR_RST_CONV_BOOST),
        .WDT_MASK (CCR_WDT_CONV_BOOST),
        .WR_MASK  (CCR_WR_CONV_BOOST),
        .HW_MASK  (8'h00)
    ) u_conv (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_soft_rst(soft_rst),
        .i_wdt     (i_watchdog_expiry),
        .i_wr_en   (wr_conv),
        .i_wr_data (shift_ff),
        .i_hw_load (1'b0),
        .i_hw_data (8'h00),
        .o_value   (reg_conv)
    );

    ccr_cfg_byte #(
        .RST_VAL  (CCR_RST_CHG_SYS),
        .WDT_MASK (CCR_WDT_CHG_SYS),
        .WR_MASK  (CCR_WR_CHG_SYS),
        .HW_MASK  (8'h00)
    ) u_chg (
        .i_mclk    (i_mclk),
        .i_sys_rst (i_sys_rst),
        .i_soft_rst(soft_rst),
        .i_wdt     (i_watchdog_expiry),
        .i_wr_en   (wr_chg),
        .i_wr_data (shift_ff),
        .i_hw_load (1'b0),
        .i_hw_data (8'h00),
        .o_value   (reg_chg)
    );

    // the stored repeat bit decides, so a write that sets go and repeat together starts a conversion only while the stored repeat bit is clear
    always_comb
    begin
        nxt_adc_go = adc_go_ff;
        if (i_adc_done)
        begin
            nxt_adc_go = 1'b0;
        end
        if (wr_conv && !reg_conv[CCR_POS_ADC_REPEAT])
        begin
            nxt_adc_go = shift_ff[CCR_POS_ADC_GO];
        end
        if (soft_rst || i_watchdog_expiry)
        begin
            nxt_adc_go = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            adc_go_ff <= 1'b0;
        end
        else
        begin
            adc_go_ff <= nxt_adc_go;
        end
    end

    assign o_vin_floor_code                = reg_vin[6:0];
    assign o_ship_delay_en                 = reg_thermal[CCR_POS_SHIP_DLY];
    assign o_thermistor_profile            = reg_thermal[CCR_POS_NTC_PROFILE];
    assign o_boost_thermistor_enable       = reg_thermal[CCR_POS_BOOST_NTC];
    assign o_charge_thermistor_enable      = reg_thermal[CCR_POS_CHG_NTC];
    assign o_die_temp_thr                  = reg_thermal[CCR_POS_DIE_THR +: 2];
    assign o_thermistor_source_sel         = reg_thermal[CCR_POS_NTC_SRC];
    assign o_auto_input_current_opt_enable = reg_thermal[CCR_POS_AICO];
    assign o_adc_go                        = adc_go_ff;
    assign o_adc_continuous                = reg_conv[CCR_POS_ADC_REPEAT];
    assign o_boost_voltage_set             = reg_conv[CCR_POS_BOOST_V +: 3];
    assign o_boost_current_limit           = reg_conv[CCR_POS_BOOST_I +: 3];
    assign o_battery_load_enable           = reg_chg[CCR_POS_BAT_LOAD];
    assign o_status_pin_enable             = reg_chg[CCR_POS_STAT_EN];
    assign o_charge_function_sel           = reg_chg[CCR_POS_CHG_FUNC +: 2];
    assign o_sys_floor_code                = reg_chg[CCR_POS_SYS_FLOOR +: 3];
    assign o_battery_track_offset          = reg_chg[CCR_POS_TRACK];

endmodule

// File: ccr_charger_cfg_assertions.sv
// concurrent checks on the charger configuration register bank ports
module ccr_charger_cfg_assertions
    import ccr_pkg::*;
(
    input wire logic       i_mclk,
    input wire logic       i_sys_rst,
    input wire logic       i_scl,
    input wire logic       o_sda,
    input wire logic       o_sda_oe_n,
    input wire logic       i_watchdog_expiry,
    input wire logic       i_vin_power_up,
    input wire logic [6:0] i_otp_vin_floor,
    input wire logic       i_adc_done,
    input wire logic       o_adc_go,
    input wire logic [6:0] o_vin_floor_code,
    input wire logic       o_charge_thermistor_enable,
    input wire logic [1:0] o_die_temp_thr,
    input wire logic [2:0] o_boost_voltage_set,
    input wire logic [1:0] o_charge_function_sel,
    input wire logic [2:0] o_sys_floor_code,
    input wire logic       o_battery_track_offset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    // a power-up load in the same cycle outranks the watchdog
    sequence s_wdt;
        i_watchdog_expiry && !i_vin_power_up;
    endsequence
    sequence s_go_done;
        o_adc_go ##1 i_adc_done;
    endsequence
    a_por_values: assert property ($fell(i_sys_rst) |-> o_vin_floor_code == 7'h06 && o_die_temp_thr == 2'h3)
        else $error("bad power-on value");
    a_sda_drive_phase: assert property (o_sda == 1'b0 && (!$changed(o_sda_oe_n) || !i_scl))
        else $error("data pin moved while clock high");
    a_wdt_thermal: assert property (s_wdt |=> o_charge_thermistor_enable && o_die_temp_thr == 2'h3)
        else $error("thermal not restored");
    a_wdt_boost_cfg: assert property (s_wdt |=> o_boost_voltage_set == 3'h2 && o_charge_function_sel == 2'h1)
        else $error("boost or function not restored");
    a_wdt_keeps_floor: assert property (s_wdt |=> $stable(o_vin_floor_code))
        else $error("floor changed by watchdog");
    a_wdt_keeps_sys: assert property (s_wdt |=> $stable(o_sys_floor_code) && $stable(o_battery_track_offset))
        else $error("system floor changed by watchdog");
    a_power_up_load: assert property (i_vin_power_up |=> o_vin_floor_code == $past(i_otp_vin_floor))
        else $error("floor not loaded on power-up");
    a_done_clears_go: assert property (s_go_done |=> !o_adc_go)
        else $error("go bit not cleared");
endmodule

bind ccr_charger_cfg ccr_charger_cfg_assertions u_chk (.*);

// File: ccr_host_model.sv
// behavioural two-wire bus master standing in for the host processor
module ccr_host_model
    import ccr_pkg::*;
(
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    // clock moves first so a data change never lands inside a clock edge
    task automatic step(input logic c, input logic d);
        o_scl <= c;
        repeat (4) @(posedge i_mclk);
        o_sda <= d;
        repeat (8) @(posedge i_mclk);
    endtask
    task automatic start();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic stop();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] d, input logic m9, output logic [7:0] q, output logic nak);
        for (int i = 7; i >= 0; i--)
        begin
            step(1'b0, d[i]);
            step(1'b1, d[i]);
            q[i] = i_sda;
        end
        step(1'b0, m9);
        step(1'b1, m9);
        nak = i_sda;
    endtask
    task automatic wr(input logic [6:0] sa, input logic [7:0] ra, input logic [7:0] d, output logic acked);
        logic [7:0] q;
        logic [2:0] n;
        start();
        xfer({sa, 1'b0}, 1'b1, q, n[0]);
        xfer(ra, 1'b1, q, n[1]);
        xfer(d, 1'b1, q, n[2]);
        stop();
        acked = (n == 3'h0);
    endtask
    task automatic rd(input logic [7:0] ra, output logic [7:0] q);
        logic [7:0] x;
        logic       n;
        start();
        xfer({CCR_SLAVE_ADDR, 1'b0}, 1'b1, x, n);
        xfer(ra, 1'b1, x, n);
        start();
        xfer({CCR_SLAVE_ADDR, 1'b1}, 1'b1, x, n);
        xfer(8'hFF, 1'b1, q, n);
        stop();
    endtask
    // two-byte read: master acks the first byte, nacks the second
    task automatic rd2(input logic [7:0] ra, output logic [15:0] q);
        logic [7:0] x;
        logic       n;
        start();
        xfer({CCR_SLAVE_ADDR, 1'b0}, 1'b1, x, n);
        xfer(ra, 1'b1, x, n);
        start();
        xfer({CCR_SLAVE_ADDR, 1'b1}, 1'b1, x, n);
        xfer(8'hFF, 1'b0, q[15:8], n);
        xfer(8'hFF, 1'b1, q[7:0], n);
        stop();
    endtask
endmodule

// File: ccr_charger_cfg_bench.sv
// self-checking bench for the charger configuration register bank
module ccr_charger_cfg_bench
    import ccr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [7:0] ofs; logic [7:0] wr; logic [7:0] rd;} ccr_row_t;
    localparam ccr_row_t ROWS [6] = '{24'h022323, 24'h033F3F, 24'h04A4A4, 24'h017F7F, 24'h055500, 24'h00AA00};
    logic       i_mclk = 1'b0;
    logic       i_sys_rst = 1'b1;
    logic       i_scl, host_sda, i_sda, o_sda, o_sda_oe_n, ack;
    logic       i_watchdog_expiry = 1'b0, i_vin_power_up = 1'b0, i_adc_busy = 1'b0, i_adc_done = 1'b0;
    logic [6:0] i_otp_vin_floor = 7'h15;
    logic [6:0] o_vin_floor_code;
    logic [1:0] o_die_temp_thr, o_charge_function_sel;
    logic [2:0] o_boost_voltage_set, o_boost_current_limit, o_sys_floor_code;
    logic       o_ship_delay_en, o_thermistor_profile, o_boost_thermistor_enable, o_charge_thermistor_enable;
    logic       o_thermistor_source_sel, o_auto_input_current_opt_enable, o_adc_go, o_adc_continuous;
    logic       o_battery_load_enable, o_status_pin_enable, o_battery_track_offset;
    logic [7:0] q;
    logic [15:0] w;
    wire [7:0]  out_thermal = {o_ship_delay_en, o_thermistor_profile, o_boost_thermistor_enable,
                               o_charge_thermistor_enable, o_die_temp_thr, o_thermistor_source_sel,
                               o_auto_input_current_opt_enable};
    wire [7:0]  out_conv    = {o_adc_go, o_adc_continuous, o_boost_voltage_set, o_boost_current_limit};
    wire [7:0]  out_chg     = {o_battery_load_enable, o_status_pin_enable, o_charge_function_sel,
                               o_sys_floor_code, o_battery_track_offset};
    int         n_errors = 0, total_checks = 0, cycles = 0;
    // pulled-up wire: low whenever any party pulls it low
    assign i_sda = host_sda & (o_sda_oe_n | o_sda);
    always #5 i_mclk = ~i_mclk;
    ccr_charger_cfg uut (.*);
    ccr_host_model u_host (.i_mclk(i_mclk), .i_sda(i_sda), .o_scl(i_scl), .o_sda(host_sda));
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_reg({7'h00, got}, {7'h00, exp});
    endtask
    task automatic chk_all(input logic [31:0] e);
        for (int k = 0; k < 4; k++)
        begin
            u_host.rd(8'(k + 1), q);
            chk_reg(q, e[31 - 8 * k -: 8]);
        end
        chk_reg({1'b0, o_vin_floor_code}, e[31:24]);
        chk_reg(out_thermal, e[23:16]);
        chk_reg(out_conv, e[15:8]);
        chk_reg(out_chg, e[7:0]);
    endtask
    always @(posedge i_mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (6) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (10) @(posedge i_mclk);
        foreach (ROWS[k])
        begin
            u_host.wr(CCR_SLAVE_ADDR, ROWS[k].ofs, ROWS[k].wr, ack);
            chk_bit(ack, 1'b1);
            u_host.rd(ROWS[k].ofs, q);
            chk_reg(q, ROWS[k].rd);
        end
        // a wrongly accepted frame would zero the last register
        u_host.wr(CCR_SLAVE_ADDR ^ 7'h01, 8'h04, 8'h00, ack);
        chk_bit(ack, 1'b0);
        i_watchdog_expiry <= 1'b1;
        @(posedge i_mclk);
        i_watchdog_expiry <= 1'b0;
        chk_all(32'h7FDD1054);
        i_vin_power_up <= 1'b1;
        @(posedge i_mclk);
        i_vin_power_up <= 1'b0;
        @(posedge i_mclk);
        chk_reg({1'b0, o_vin_floor_code}, 8'h15);
        u_host.wr(CCR_SLAVE_ADDR, 8'h01, 8'h80, ack);
        chk_all(32'h06DC105B);
        u_host.wr(CCR_SLAVE_ADDR, 8'h03, 8'h90, ack);
        chk_bit(o_adc_go, 1'b1);
        i_adc_done <= 1'b1;
        @(posedge i_mclk);
        i_adc_done <= 1'b0;
        @(posedge i_mclk);
        chk_bit(o_adc_go, 1'b0);
        i_adc_busy <= 1'b1;
        u_host.rd(8'h03, q);
        chk_reg(q, 8'h90);
        i_adc_busy <= 1'b0;
        u_host.wr(CCR_SLAVE_ADDR, 8'h03, 8'h50, ack);
        chk_bit(o_adc_continuous, 1'b1);
        u_host.wr(CCR_SLAVE_ADDR, 8'h03, 8'hD0, ack);
        chk_bit(o_adc_go, 1'b0);
        u_host.rd(8'h03, q);
        chk_reg(q, 8'h50);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (10) @(posedge i_mclk);
        chk_all(32'h06DC105B);
        u_host.rd2(8'h02, w);
        chk_reg(w[15:8], 8'hDC);
        chk_reg(w[7:0], 8'h10);
        tally_and_finish();
    end
endmodule
